// File: rtl/alu_pkg.sv
// Shared constants, types and register map for the ALU saturate/divide/flags block
package alu_pkg;

  // Register byte offsets on the AHB-Lite slave (haddr[7:0])
  localparam logic [7:0] OFF_X0 = 8'h00;
  localparam logic [7:0] OFF_X1 = 8'h04;
  localparam logic [7:0] OFF_Y0 = 8'h08;
  localparam logic [7:0] OFF_Y1 = 8'h0C;
  localparam logic [7:0] OFF_FB = 8'h10;
  localparam logic [7:0] OFF_RES = 8'h14;
  localparam logic [7:0] OFF_MODE = 8'h18;
  localparam logic [7:0] OFF_FLAGS = 8'h1C;
  localparam logic [7:0] OFF_CMD = 8'h20;

  // Field positions in mode_status_reg
  localparam int SAT_BIT = 3;
  localparam int STICKY_BIT = 2;

  // Values after reset
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic RST_MODE = 1'b0;

  // Saturation limits
  localparam logic [15:0] SAT_POS = 16'h7FFF;
  localparam logic [15:0] SAT_NEG = 16'h8000;

  // Cycles a read holds hreadyout low before the data phase ends
  localparam int READ_WAIT_CYCLES = 1;

  typedef enum logic [3:0] {
    OP_NOP, OP_ADD, OP_ADDC, OP_SUB_XY, OP_SUBB_XY, OP_SUB_YX, OP_PASS_X, OP_PASS_Y,
    OP_ABS, OP_DIVIDE_SIGN_STEP, OP_DIVIDE_QUOTIENT_STEP, OP_ENA_SAT, OP_DIS_SAT, OP_ENA_STK, OP_DIS_STK
  } alu_op_t;

  typedef enum logic [1:0] {XS_X0, XS_X1, XS_RES} xsel_t;
  typedef enum logic [1:0] {YS_Y0, YS_Y1, YS_FB} ysel_t;
  typedef enum logic [1:0] {DST_RES, DST_FB, DST_NONE} dest_t;

  // Command word, written to OFF_CMD in hwdata[9:0]
  typedef struct packed {
    alu_op_t op;
    xsel_t xsel;
    ysel_t ysel;
    dest_t dest;
  } cmd_t;

  // alu_flag_word layout: bit 0 zero ... bit 5 quotient
  typedef struct packed {
    logic quot;
    logic xsign;
    logic cout;
    logic ovf;
    logic neg;
    logic zero;
  } flags_t;

  localparam flags_t RST_FLAGS = 6'h00;

  typedef struct packed {
    logic v;
    logic c;
    logic [15:0] r;
  } sum_t;

endpackage : alu_pkg

// File: rtl/alu_saturate_divide_flags.sv
// ALU result saturation, sticky overflow, divide primitives and status flags behind AHB-Lite
`timescale 1ns/1ps

module alu_saturate_divide_flags
  import alu_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  ////////////////////////////////////////////////////////////////////////////////
  // Adder with carries out of both top stages

  function automatic sum_t add16(input logic [15:0] a, input logic [15:0] b, input logic ci);
    logic [15:0] low;
    logic [1:0] top;
    sum_t s;
    low = {1'b0, a[14:0]} + {1'b0, b[14:0]} + {15'h0000, ci};
    top = {1'b0, a[15]} + {1'b0, b[15]} + {1'b0, low[15]};
    s.r = {top[0], low[14:0]};
    s.c = top[1];
    s.v = top[1] ^ low[15];
    return s;
  endfunction : add16

  ////////////////////////////////////////////////////////////////////////////////
  // State

  logic [15:0] x0_q, x1_q, y0_q, y1_q, fb_q, res_q;
  logic sat_q;
  logic stk_q;
  flags_t flags_q;
  logic [7:0] addr_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic accept;
  logic wr_en;
  cmd_t cmd;
  logic op_go;

  assign accept = hsel && htrans[1] && hready;
  assign wr_en = wr_pend_q;
  assign cmd = cmd_t'(hwdata[9:0]);
  // A command executes in the data phase of its write, one operation per write
  assign op_go = wr_en && (addr_q == OFF_CMD);

  function automatic logic wr_to(input logic [7:0] off, input logic en, input logic [7:0] a);
    return en && (a == off);
  endfunction : wr_to

  ////////////////////////////////////////////////////////////////////////////////
  // Datapath

  logic [15:0] xin, yin;
  sum_t sum;
  logic [15:0] out_val;
  logic [15:0] sat_val;
  logic arith;
  logic is_div;
  logic new_quot;
  logic [15:0] div_fb, div_y0;

  always_comb begin
    unique case (cmd.xsel)
      XS_X0: xin = x0_q;
      XS_X1: xin = x1_q;
      XS_RES: xin = res_q;
      default: xin = x0_q;
    endcase
    unique case (cmd.ysel)
      YS_Y0: yin = y0_q;
      YS_Y1: yin = y1_q;
      YS_FB: yin = fb_q;
      default: yin = y0_q;
    endcase
  end

  always_comb begin
    arith = 1'b1;
    is_div = 1'b0;
    new_quot = flags_q.quot;
    unique case (cmd.op)
      OP_ADD: sum = add16(xin, yin, 1'b0);
      OP_ADDC: sum = add16(xin, yin, flags_q.cout);
      OP_SUB_XY: sum = add16(xin, ~yin, 1'b1);
      OP_SUBB_XY: sum = add16(xin, ~yin, flags_q.cout);
      OP_SUB_YX: sum = add16(yin, ~xin, 1'b1);
      OP_PASS_X: sum = add16(xin, 16'h0000, 1'b0);
      OP_PASS_Y: sum = add16(16'h0000, yin, 1'b0);
      OP_ABS: begin
        if (xin[15]) begin
          sum = add16(16'h0000, ~xin, 1'b1);
        end else begin
          sum = add16(xin, 16'h0000, 1'b0);
        end
      end
      OP_DIVIDE_SIGN_STEP: begin
        // ALU passes Y straight through
        sum = add16(16'h0000, yin, 1'b0);
        is_div = 1'b1;
        new_quot = xin[15] ^ yin[15];
      end
      OP_DIVIDE_QUOTIENT_STEP: begin
        if (flags_q.quot) begin
          sum = add16(yin, xin, 1'b0);
        end else begin
          sum = add16(yin, ~xin, 1'b1);
        end
        is_div = 1'b1;
        new_quot = xin[15] ^ sum.r[15];
      end
      default: begin
        sum = add16(16'h0000, 16'h0000, 1'b0);
        arith = 1'b0;
      end
    endcase
  end

  // Clamp from this cycle's overflow and carry, not from the stored flags
  always_comb begin
    out_val = sum.r;
    if (sat_q && sum.v) begin
      sat_val = sum.c ? SAT_NEG : SAT_POS;
    end else begin
      sat_val = sum.r;
    end
  end

  // Divide shifts the feedback:y0 pair left; quotient bit enters y0 LSB
  always_comb begin
    div_fb = {sum.r[14:0], y0_q[15]};
    if (cmd.op == OP_DIVIDE_SIGN_STEP) begin
      div_y0 = {y0_q[14:0], new_quot};
    end else begin
      div_y0 = {y0_q[14:0], ~new_quot};
    end
  end

  logic alu_go;
  logic div_go;
  assign alu_go = op_go && arith && !is_div;
  assign div_go = op_go && is_div;

  ////////////////////////////////////////////////////////////////////////////////
  // Operand registers

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      x0_q <= RST_WORD;
      x1_q <= RST_WORD;
      y1_q <= RST_WORD;
    end else begin
      if (wr_to(OFF_X0, wr_en, addr_q)) begin
        x0_q <= hwdata[15:0];
      end
      if (wr_to(OFF_X1, wr_en, addr_q)) begin
        x1_q <= hwdata[15:0];
      end
      if (wr_to(OFF_Y1, wr_en, addr_q)) begin
        y1_q <= hwdata[15:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      y0_q <= RST_WORD;
    end else if (div_go) begin
      y0_q <= div_y0;
    end else if (wr_to(OFF_Y0, wr_en, addr_q)) begin
      y0_q <= hwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result and feedback registers

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      res_q <= RST_WORD;
    end else if (alu_go && cmd.dest == DST_RES) begin
      res_q <= sat_val;
    end else if (wr_to(OFF_RES, wr_en, addr_q)) begin
      res_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fb_q <= RST_WORD;
    end else if (div_go) begin
      fb_q <= div_fb;
    end else if (alu_go && cmd.dest == DST_FB) begin
      fb_q <= out_val;
    end else if (wr_to(OFF_FB, wr_en, addr_q)) begin
      fb_q <= hwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode bits

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sat_q <= RST_MODE;
      stk_q <= RST_MODE;
    end else if (op_go) begin
      if (cmd.op == OP_ENA_SAT) begin
        sat_q <= 1'b1;
      end
      if (cmd.op == OP_DIS_SAT) begin
        sat_q <= 1'b0;
      end
      if (cmd.op == OP_ENA_STK) begin
        stk_q <= 1'b1;
      end
      if (cmd.op == OP_DIS_STK) begin
        stk_q <= 1'b0;
      end
    end else if (wr_to(OFF_MODE, wr_en, addr_q)) begin
      sat_q <= hwdata[SAT_BIT];
      stk_q <= hwdata[STICKY_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status flags, captured at the end of the operating cycle

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= RST_FLAGS;
    end else if (alu_go) begin
      // Flags follow the saturated value whichever register is loaded
      flags_q.zero <= ~|sat_val;
      flags_q.neg <= sat_val[15];
      flags_q.cout <= sum.c;
      if (stk_q) begin
        flags_q.ovf <= flags_q.ovf | sum.v;
      end else begin
        flags_q.ovf <= sum.v;
      end
      if (cmd.op == OP_ABS) begin
        flags_q.xsign <= xin[15];
      end
    end else if (div_go) begin
      flags_q.quot <= new_quot;
    end else if (wr_to(OFF_FLAGS, wr_en, addr_q)) begin
      // Direct write clears a sticky overflow; so does reset, or an ALU op without overflow once sticky mode is off
      flags_q <= flags_t'(hwdata[5:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes take effect at the end of the data phase

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 8'h00;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      if (accept) begin
        addr_q <= haddr[7:0];
        wr_pend_q <= hwrite;
        rd_pend_q <= !hwrite;
      end else begin
        wr_pend_q <= 1'b0;
        rd_pend_q <= 1'b0;
      end
    end
  end

  // One wait state on reads so a write just ahead is already visible
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout_q <= 1'b1;
    end else if (accept && !hwrite) begin
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      unique case (addr_q)
        OFF_X0: hrdata_q <= {16'h0000, x0_q};
        OFF_X1: hrdata_q <= {16'h0000, x1_q};
        OFF_Y0: hrdata_q <= {16'h0000, y0_q};
        OFF_Y1: hrdata_q <= {16'h0000, y1_q};
        OFF_FB: hrdata_q <= {16'h0000, fb_q};
        OFF_RES: hrdata_q <= {16'h0000, res_q};
        OFF_MODE: hrdata_q <= {28'h000_0000, sat_q, stk_q, 2'b00};
        OFF_FLAGS: hrdata_q <= {26'h000_0000, flags_q};
        default: hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;

endmodule : alu_saturate_divide_flags

// File: bench/alu_checker_properties.sv
// Port-level checks of the ALU saturate/divide/flags block
`timescale 1ns/1ps
module alu_checker
  import alu_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic tk;
  logic wr_q;
  logic [7:0] adr_q;
  logic [1:0] mode_q;
  assign tk = hsel & htrans[1] & hready;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) wr_q <= 1'b0;
    else wr_q <= tk & hwrite;
  end
  always_ff @(posedge mclk) adr_q <= haddr[7:0];
  // Shadow of both modes; ops 11..14 pick a mode by op < 13, new value in op[0]
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) mode_q <= 2'b00;
    else if (wr_q && adr_q == OFF_MODE) mode_q <= hwdata[3:2];
    else if (wr_q && adr_q == OFF_CMD && hwdata[9:6] inside {[4'hB:4'hE]})
      mode_q[hwdata[9:6] < 4'hD] <= hwdata[6];
  end
  a_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait cycle");
  a_write_fast: assert property (tk && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_wait_cause: assert property ($fell(hreadyout) |-> $past(tk && !hwrite))
    else $error("wait state without a read");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_mode_back: assert property (tk && !hwrite && haddr[7:0] == OFF_MODE
    |-> ##2 hrdata[3:2] == mode_q) else $error("mode bits differ from shadow");
  a_mode_upper: assert property (tk && !hwrite && haddr[7:0] == OFF_MODE
    |-> ##2 hrdata[31:4] == 28'h0) else $error("mode upper bits set");
  a_flags_upper: assert property (tk && !hwrite && haddr[7:0] == OFF_FLAGS
    |-> ##2 hrdata[31:6] == 26'h0) else $error("flag word upper bits set");
  a_cmd_zero: assert property (tk && !hwrite && haddr[7:0] >= OFF_CMD
    |-> ##2 hrdata == 32'h0) else $error("command or unmapped read not zero");
  c_div: cover property (wr_q && adr_q == OFF_CMD && hwdata[9:6] == 4'hA);
  c_both: cover property (mode_q == 2'b11);
  c_flags: cover property (tk && !hwrite && haddr[7:0] == OFF_FLAGS);
endmodule : alu_checker

bind alu_saturate_divide_flags alu_checker chk (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// File: bench/ahb_host.sv
// AHB-Lite master standing in for the decoder and sequencer
`timescale 1ns/1ps
module ahb_host (
  // Clock and bus return
  input wire logic mclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Entered just after a rising edge; each phase is held until a rising edge
  // samples hready high, so any wait state of the slave is honoured
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
endmodule : ahb_host

// File: bench/tb.sv
// Self-checking bench of the ALU saturate/divide/flags block
`timescale 1ns/1ps
module tb
  import alu_pkg::*;
;
  typedef struct {
    alu_op_t op;
    logic [15:0] x, y, res;
    logic [5:0] fl, mk;
  } row_t;
  logic mclk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  row_t rw[10];
  logic [15:0] ey0, efb;
  logic eq;
  // Divisor magnitude kept above the dividend upper half
  logic [15:0] dv[2] = '{16'h0300, 16'hC000};
  logic [15:0] hi[2] = '{16'h0001, 16'h1000};
  logic [15:0] lo[2] = '{16'h2000, 16'h0000};
  assign hready = hreadyout;
  alu_saturate_divide_flags DUT (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  ahb_host host (.mclk(mclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rchk
  task automatic ld(input logic [15:0] x, input logic [15:0] y);
    wr(OFF_X0, {16'h0, x});
    wr(OFF_Y0, {16'h0, y});
  endtask : ld
  task automatic run(input alu_op_t o, input ysel_t ys, input dest_t ds);
    cmd_t c;
    c = '{o, XS_X0, ys, ds};
    wr(OFF_CMD, {22'h0, c});
  endtask : run
  // One divide primitive on the expected state: sign step when s
  task automatic dstep(input logic s, input logic [15:0] x, input logic [15:0] y);
    logic [15:0] r;
    r = s ? y : (eq ? efb + x : efb - x);
    eq = s ? x[15] ^ y[15] : x[15] ^ r[15];
    efb = {r[14:0], ey0[15]};
    ey0 = {ey0[14:0], s ? eq : ~eq};
  endtask : dstep
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      end_sim;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rw[0] = '{OP_ADD, 16'h0001, 16'h0002, 16'h0003, 6'h00, 6'h0F};
    rw[1] = '{OP_ADD, 16'hFFFF, 16'h0001, 16'h0000, 6'h09, 6'h0F};
    rw[2] = '{OP_ADDC, 16'h0001, 16'h0001, 16'h0003, 6'h00, 6'h0F};
    rw[3] = '{OP_ADD, 16'h7FFF, 16'h0001, 16'h8000, 6'h06, 6'h0F};
    rw[4] = '{OP_SUB_XY, 16'h0000, 16'h0001, 16'hFFFF, 6'h02, 6'h0F};
    rw[5] = '{OP_ABS, 16'hFFFE, 16'h0000, 16'h0002, 6'h10, 6'h33};
    rw[6] = '{OP_PASS_Y, 16'h0005, 16'h0000, 16'h0000, 6'h11, 6'h33};
    rw[7] = '{OP_SUBB_XY, 16'h0005, 16'h0003, 16'h0001, 6'h08, 6'h0F};
    rw[8] = '{OP_SUB_YX, 16'h0005, 16'h0003, 16'hFFFE, 6'h02, 6'h0F};
    rw[9] = '{OP_PASS_X, 16'h8001, 16'h0000, 16'h8001, 6'h02, 6'h0F};
    rst_n = 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    // Rows run in order: carries of rows 1 and 6 feed rows 2 and 7
    foreach (rw[i]) begin
      ld(rw[i].x, rw[i].y);
      run(rw[i].op, YS_Y0, DST_RES);
      rchk(OFF_RES, {16'h0, rw[i].res});
      rchk(OFF_FLAGS, {26'h0, rw[i].fl}, {26'h0, rw[i].mk});
    end
    $display("table done");
    wr(OFF_MODE, 32'h8);
    ld(16'h7FFF, 16'h0001);
    run(OP_ADD, YS_Y0, DST_RES);
    rchk(OFF_RES, 32'h7FFF);
    rchk(OFF_FLAGS, 32'h04, 32'h0F);
    ld(16'h8000, 16'h0001);
    run(OP_SUB_XY, YS_Y0, DST_RES);
    rchk(OFF_RES, 32'h8000);
    rchk(OFF_FLAGS, 32'h0E, 32'h0F);
    ld(16'h7FFF, 16'h0001);
    run(OP_ADD, YS_Y0, DST_FB);
    rchk(OFF_FB, 32'h8000);
    rchk(OFF_FLAGS, 32'h04, 32'h0F);
    run(OP_DIS_SAT, YS_Y0, DST_NONE);
    run(OP_ADD, YS_Y0, DST_RES);
    rchk(OFF_RES, 32'h8000);
    $display("saturate done");
    run(OP_ENA_STK, YS_Y0, DST_NONE);
    run(OP_ADD, YS_Y0, DST_NONE);
    ld(16'h0001, 16'h0002);
    run(OP_ADD, YS_Y0, DST_NONE);
    rchk(OFF_FLAGS, 32'h04, 32'h04);
    wr(OFF_FLAGS, 32'h0);
    rchk(OFF_FLAGS, 32'h00, 32'h3F);
    rchk(OFF_MODE, 32'h4);
    run(OP_DIS_STK, YS_Y0, DST_NONE);
    run(OP_ENA_SAT, YS_Y0, DST_NONE);
    rchk(OFF_MODE, 32'h8);
    $display("sticky done");
    for (int k = 0; k < 2; k++) begin
      ld(dv[k], lo[k]);
      wr(k ? OFF_Y1 : OFF_FB, {16'h0, hi[k]});
      wr(OFF_FLAGS, 32'h0);
      ey0 = lo[k];
      efb = hi[k];
      eq = 1'b0;
      if (k == 1) begin
        run(OP_DIVIDE_SIGN_STEP, YS_Y1, DST_FB);
        dstep(1'b1, dv[k], hi[k]);
      end
      for (int n = 0; n < 16 - k; n++) begin
        run(OP_DIVIDE_QUOTIENT_STEP, YS_FB, DST_FB);
        dstep(1'b0, dv[k], 16'h0);
      end
      rchk(OFF_Y0, {16'h0, ey0});
      // Integer operands unshifted: quotient is half the dividend over the divisor
      if (k == 0) begin
        rchk(OFF_Y0, 32'h0000_0030);
      end
      rchk(OFF_FB, {16'h0, efb});
      rchk(OFF_FLAGS, {26'h0, eq, 5'h0}, 32'h20);
    end
    $display("divide done");
    wr(OFF_MODE, 32'hC);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rchk(OFF_MODE, 32'h0);
    rchk(OFF_CMD, 32'h0);
    rchk(8'h40, 32'h0);
    ld(16'h7FFF, 16'h0001);
    run(OP_ADD, YS_Y0, DST_RES);
    rchk(OFF_RES, 32'h8000);
    ld(16'h0001, 16'h0002);
    run(OP_ADD, YS_Y0, DST_NONE);
    rchk(OFF_FLAGS, 32'h0, 32'h04);
    $display("reset done");
    end_sim;
  end
endmodule : tb
